// *** design/adcc_ctrl.sv ***
// converter control registers, AHB-Lite slave, clock divider and pin gating
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "adcc_params.svh"

////////////////////////////////////////////////////////////////////////////
// register map: byte offsets, one byte in the low lane of each word
//   0x00 conversion_control
//        bit 7    start request, rests low
//        bit 6    busy flag, read only
//        bit 5    converter power enable
//        bit 4    result justify, 1 = right aligned
//        bit 3:0  external channel, 1xxx = none
//   0x04 source_and_clock_select
//        bit 7:5  input source
//        bit 4:3  reference select
//        bit 2:0  converter clock divider
//   0x08 result high byte, read only
//   0x0c result low byte, read only
//   0x10 analog pin select, bit n = pin n
//   0x14 to 0x1c unmapped: read zero, writes dropped
//   only address bits 4:2 decoded, higher words alias
//
// result layout
//   justify 0: high = result 11:4, low = result 3:0 then four zeros
//   justify 1: high = four zeros then result 11:8, low = result 7:0
//   layout chosen at read time from the current justify bit
//   result kept while power is off
//
// input source decode
//   001      bandgap voltage
//   010..100 ground
//   000, 101..111 external channel
//   channel enables all low unless external and channel below 8
//
// reference decode
//   01       internal supply
//   00, 1x   reference pin
//
// bus timing
//   address phase taken on select, nonsequential or sequential transfer and ready
//   data phase has one wait state, ready low for one cycle
//   read data registered at the end of the wait
//   next address phase accepted in the response cycle
//   response always okay, size ignored
//
// conversion flow
//   write start high, then low again with power still set
//   busy rises and the core sees one start pulse
//   start sequence ignored while busy or with power low
//   done from the core clears busy and stores the result
//   one request pulse follows each accepted done
//   power off while busy aborts: busy clears, no request; a done in the first cycle off still requests, result not stored
//   start only from idle, so start and done never meet
//
// converter clock
//   field n gives one enable pulse every 2^n cycles
//   000 every cycle, 111 once per 128 cycles
//   counter held at zero while power is off
//
// analog pins
//   selected pins lose output enable, output value and pull-up
//   selection wins over the port direction setting
//
// software duties, not enforced here
//   bandgap source needs channel field parked at 1xxx
//   internal reference needs the reference pin function off
//
// reset
//   all registers zero: power off, channel 0, external source
//   bus idle, ready high
////////////////////////////////////////////////////////////////////////////
module adcc_ctrl
    import adcc_pkg::*;
(
    input  wire logic                 SYS_CLK,       // system clock, 100 MHz
    input  wire logic                 ARST_N,        // async reset, active low
    input  wire logic                 HSEL,          // slave select
    input  wire logic [31:0]          HADDR,         // byte address
    input  wire logic [1:0]           HTRANS,        // transfer type
    input  wire logic                 HWRITE,        // write when high
    input  wire logic [2:0]           HSIZE,         // transfer size
    input  wire logic                 HREADY,        // bus ready in
    input  wire logic [31:0]          HWDATA,        // write data
    output logic      [31:0]          HRDATA,        // read data
    output logic                      HREADYOUT,     // slave ready
    output logic                      HRESP,         // always okay
    input  wire logic                 CONV_DONE,     // core finished, one pulse
    input  wire logic [11:0]          CONV_RESULT,   // core result with done
    output adcc_core_ctl_t            CORE_CTL,      // controls toward core
    output logic                      IRQ_REQ,       // done request, one pulse
    input  wire logic [7:0]           PORT_DIR_OUT,  // port drives pin when high
    input  wire logic [7:0]           PORT_DATA,     // port output value
    input  wire logic [7:0]           PORT_PULLUP,   // programmed pull-ups
    output logic      [7:0]           PIN_OE,        // pin output enable
    output logic      [7:0]           PIN_OUT,       // pin output value
    output logic      [7:0]           PIN_PULLUP_EN, // effective pull-up
    output logic      [7:0]           PIN_ANALOG_EN  // pin joined to mux
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] justify(input logic [11:0] res,
                                            input logic        right);
        logic [15:0] v;
        if (right) begin
            v = {4'h0, res};
        end else begin
            v = {res, 4'h0};
        end
        return v;
    endfunction

    function automatic logic [6:0] div_last(input logic [2:0] sel);
        logic [7:0] p;
        p = 8'h01 << sel;
        return 7'(p - 8'h01);
    endfunction

    function automatic adcc_input_t input_kind(input logic [2:0] src);
        adcc_input_t k;
        if (src == `ADCC_SRC_BANDGAP) begin
            k = ADCC_IN_BANDGAP;
        end else if (src >= `ADCC_SRC_GND_LO && src <= `ADCC_SRC_GND_HI) begin
            k = ADCC_IN_GROUND;
        end else begin
            k = ADCC_IN_EXTERNAL;
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    adcc_state_t st;
    adcc_state_t next_st;

    logic        addr_take;
    logic [7:0]  wbyte;
    logic [15:0] res_view;
    logic [7:0]  rd_byte;
    logic [2:0]  div_sel;
    logic        start_seq;
    logic        power_on;
    logic        justify_right;
    logic        start_stored;
    logic        chan_none;
    logic [2:0]  chan_num;
    logic [2:0]  src_field;
    logic [1:0]  ref_field;
    logic        dp_ctrl;
    adcc_input_t src_kind;

    assign addr_take = HSEL && HTRANS[1] && HREADY;
    assign wbyte     = HWDATA[7:0];
    assign div_sel   = st.source_and_clock_select[`ADCC_DIV_MSB:`ADCC_DIV_LSB];
    assign res_view  = justify(st.result, justify_right);

    // field decodes
    assign power_on      = st.conv_control[`ADCC_BIT_POWER];
    assign justify_right = st.conv_control[`ADCC_BIT_JUSTIFY];
    assign start_stored  = st.conv_control[`ADCC_BIT_START];
    assign chan_none     = st.conv_control[`ADCC_CH_MSB];
    assign chan_num      = st.conv_control[`ADCC_CH_MSB-1:`ADCC_CH_LSB];
    assign src_field     = st.source_and_clock_select[`ADCC_SRC_MSB:`ADCC_SRC_LSB];
    assign ref_field     = st.source_and_clock_select[`ADCC_REF_MSB:`ADCC_REF_LSB];
    assign dp_ctrl       = (st.dp_addr == `ADCC_OFS_CONV_CTRL);
    assign src_kind      = input_kind(src_field);

    always_comb begin
        unique case (st.dp_addr)
            `ADCC_OFS_CONV_CTRL: rd_byte = st.conv_control;
            `ADCC_OFS_SRC_CLK:   rd_byte = st.source_and_clock_select;
            `ADCC_OFS_RES_HIGH:  rd_byte = res_view[15:8];
            `ADCC_OFS_RES_LOW:   rd_byte = res_view[7:0];
            `ADCC_OFS_AIN_SEL:   rd_byte = st.ain_select;
            default:             rd_byte = 8'h00;
        endcase
    end

    // start sequence: stored start bit falls by a write to control
    assign start_seq = (st.phase == ADCC_PH_WAIT) && st.dp_write
                       && dp_ctrl
                       && start_stored
                       && !wbyte[`ADCC_BIT_START];

    always_comb begin
        next_st             = st;
        next_st.start_pulse = 1'b0;
        next_st.irq_pulse   = 1'b0;

        // bus slave: one wait state, then response
        unique case (st.phase)
            ADCC_PH_IDLE,
            ADCC_PH_RESP: begin
                if (addr_take) begin
                    next_st.phase    = ADCC_PH_WAIT;
                    next_st.dp_write = HWRITE;
                    next_st.dp_addr  = {HADDR[4:2], 2'b00};
                end else begin
                    next_st.phase = ADCC_PH_IDLE;
                end
            end
            ADCC_PH_WAIT: begin
                next_st.phase = ADCC_PH_RESP;
                next_st.rdata = {24'h00_0000, rd_byte};
                if (st.dp_write) begin
                    unique case (st.dp_addr)
                        `ADCC_OFS_CONV_CTRL: begin
                            next_st.conv_control = {wbyte[7], st.conv_control[`ADCC_BIT_BUSY],
                                                    wbyte[5:0]};
                        end
                        `ADCC_OFS_SRC_CLK: next_st.source_and_clock_select = wbyte;
                        `ADCC_OFS_AIN_SEL: next_st.ain_select = wbyte;
                        default: next_st.rdata = st.rdata;
                    endcase
                end
            end
            default: next_st.phase = ADCC_PH_IDLE;
        endcase

        // conversion control
        if (start_seq && !st.busy && wbyte[`ADCC_BIT_POWER]) begin
            next_st.busy        = 1'b1;
            next_st.start_pulse = 1'b1;
        end else if (st.busy && CONV_DONE) begin
            next_st.busy      = 1'b0;
            next_st.irq_pulse = 1'b1;
            if (power_on) begin
                next_st.result = CONV_RESULT;
            end
        end else if (st.busy && !power_on) begin
            next_st.busy = 1'b0;
        end
        next_st.conv_control[`ADCC_BIT_BUSY] = next_st.busy;

        // converter clock enable
        if (!power_on || st.div_cnt >= div_last(div_sel)) begin
            next_st.div_cnt = 7'h00;
        end else begin
            next_st.div_cnt = 7'(st.div_cnt + 7'h01);
        end
        next_st.clk_en = power_on
                         && (st.div_cnt >= div_last(div_sel));
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st                         <= '0;
            st.conv_control            <= `ADCC_RST_CONV_CTRL;
            st.source_and_clock_select <= `ADCC_RST_SRC_CLK;
            st.ain_select              <= `ADCC_RST_AIN_SEL;
            st.result                  <= `ADCC_RST_RESULT;
            st.phase                   <= ADCC_PH_IDLE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign HRDATA    = st.rdata;
    assign HREADYOUT = (st.phase != ADCC_PH_WAIT);
    assign HRESP     = 1'b0;
    assign IRQ_REQ   = st.irq_pulse;

    always_comb begin
        CORE_CTL.power_en     = power_on;
        CORE_CTL.conv_start   = st.start_pulse;
        CORE_CTL.clk_en       = st.clk_en;
        CORE_CTL.input_kind   = src_kind;
        CORE_CTL.ref_internal = (ref_field == `ADCC_REF_INTERNAL);
        CORE_CTL.channel_en   = 8'h00;
        if (src_kind == ADCC_IN_EXTERNAL && !chan_none) begin
            CORE_CTL.channel_en = 8'h01 << chan_num;
        end
    end

    // analog pins lose digital drive and pull-up, whatever the direction
    assign PIN_ANALOG_EN = st.ain_select;
    assign PIN_OE        = PORT_DIR_OUT & ~st.ain_select;
    assign PIN_OUT       = PORT_DATA & ~st.ain_select;
    assign PIN_PULLUP_EN = PORT_PULLUP & ~st.ain_select;

endmodule // adcc_ctrl

// *** design/adcc_params.svh ***
// constants for the converter control block: offsets, fields, resets, counts
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

`define ADCC_OFS_CONV_CTRL   5'h00
`define ADCC_OFS_SRC_CLK     5'h04
`define ADCC_OFS_RES_HIGH    5'h08
`define ADCC_OFS_RES_LOW     5'h0C
`define ADCC_OFS_AIN_SEL     5'h10

`define ADCC_RST_CONV_CTRL   8'h00
`define ADCC_RST_SRC_CLK     8'h00
`define ADCC_RST_AIN_SEL     8'h00
`define ADCC_RST_RESULT      12'h000

`define ADCC_BIT_START       7
`define ADCC_BIT_BUSY        6
`define ADCC_BIT_POWER       5
`define ADCC_BIT_JUSTIFY     4
`define ADCC_CH_MSB          3
`define ADCC_CH_LSB          0
`define ADCC_SRC_MSB         7
`define ADCC_SRC_LSB         5
`define ADCC_REF_MSB         4
`define ADCC_REF_LSB         3
`define ADCC_DIV_MSB         2
`define ADCC_DIV_LSB         0

`define ADCC_SRC_BANDGAP     3'h1
`define ADCC_SRC_GND_LO      3'h2
`define ADCC_SRC_GND_HI      3'h4
`define ADCC_REF_INTERNAL    2'h1
`define ADCC_NUM_CH          8
`define ADCC_DIV_W           7

`endif

// *** design/adcc_pkg.sv ***
// types shared by the converter control block
package adcc_pkg;

    typedef enum logic [1:0] {
        ADCC_PH_IDLE = 2'b00,
        ADCC_PH_WAIT = 2'b01,
        ADCC_PH_RESP = 2'b10
    } adcc_phase_t;

    typedef enum logic [1:0] {
        ADCC_IN_EXTERNAL = 2'b00,
        ADCC_IN_BANDGAP  = 2'b01,
        ADCC_IN_GROUND   = 2'b10
    } adcc_input_t;

    // signals toward the analog converter core
    typedef struct packed {
        logic        power_en;
        logic        conv_start;
        logic        clk_en;
        adcc_input_t input_kind;
        logic [7:0]  channel_en;
        logic        ref_internal;
    } adcc_core_ctl_t;

    typedef struct packed {
        adcc_phase_t phase;
        logic        dp_write;
        logic [4:0]  dp_addr;
        logic [31:0] rdata;
        logic [7:0]  conv_control;
        logic [7:0]  source_and_clock_select;
        logic [7:0]  ain_select;
        logic [11:0] result;
        logic        busy;
        logic        start_pulse;
        logic        irq_pulse;
        logic [6:0]  div_cnt;
        logic        clk_en;
    } adcc_state_t;

endpackage

// *** verif/adc_control_registers_test.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_control_registers_test;
    import adcc_pkg::*;
    logic sys_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [11:0] res_val = 12'ha5c, conv_result;
    logic hreadyout, hresp, conv_done, irq_req;
    logic [7:0] port_pullup = 8'hff, pin_oe, pin_out, pin_pullup_en, pin_analog_en;
    adcc_core_ctl_t core_ctl;
    int fail_count = 0, cmp_count = 0, starts = 0, irqs = 0, ticks = 0, t0 = 0;
    // addr, write, readback, input kind, channel one-hot, inner reference
    logic [31:0] rows [9] = '{{5'h00, 8'h47, 8'h07, 2'h0, 8'h80, 1'b0},
        {5'h04, 8'h08, 8'h08, 2'h0, 8'h80, 1'b1},
        {5'h04, 8'he2, 8'he2, 2'h0, 8'h80, 1'b0},
        {5'h00, 8'h5f, 8'h1f, 2'h0, 8'h00, 1'b0},
        {5'h04, 8'h30, 8'h30, 2'h1, 8'h00, 1'b0},
        {5'h04, 8'h80, 8'h80, 2'h2, 8'h00, 1'b0},
        {5'h04, 8'ha0, 8'ha0, 2'h0, 8'h00, 1'b0},
        {5'h10, 8'ha5, 8'ha5, 2'h0, 8'h00, 1'b0},
        {5'h14, 8'hff, 8'h00, 2'h0, 8'h00, 1'b0}};
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        starts <= starts + core_ctl.conv_start;
        irqs <= irqs + irq_req;
        ticks <= ticks + core_ctl.clk_en;
    end
    adcc_ctrl u_adcc_ctrl (.SYS_CLK(sys_clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CONV_DONE(conv_done),
        .CONV_RESULT(conv_result), .CORE_CTL(core_ctl), .IRQ_REQ(irq_req), .PORT_DIR_OUT(8'hff),
        .PORT_DATA(8'h3c), .PORT_PULLUP(port_pullup), .PIN_OE(pin_oe), .PIN_OUT(pin_out),
        .PIN_PULLUP_EN(pin_pullup_en), .PIN_ANALOG_EN(pin_analog_en));
    adcc_core_model u_adcc_core_model (.SYS_CLK(sys_clk), .CORE_CTL(core_ctl), .RES_VAL(res_val),
        .CONV_DONE(conv_done), .CONV_RESULT(conv_result));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20us;
        fail_count++;
        results();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 5'(i * 4), 8'h0, rd);
            chk("reset value", 32'h0, rd);
        end
        foreach (rows[i]) begin
            bus(1'b1, rows[i][31:27], rows[i][26:19], rd);
            bus(1'b0, rows[i][31:27], 8'h0, rd);
            chk("readback", {24'h0, rows[i][18:11]}, rd);
            chk("core select", {21'h0, rows[i][10:0]}, {21'h0, core_ctl[10:0]});
        end
        chk("pull-ups", 32'h5a, {24'h0, pin_pullup_en});
        chk("pin drive", 32'h5a, {24'h0, pin_oe});
        chk("pin value", 32'h18, {24'h0, pin_out});
        chk("analog pins", 32'ha5, {24'h0, pin_analog_en});
        chk("response", 32'h0, {31'h0, hresp});
        bus(1'b1, 5'h04, 8'h03, rd);
        bus(1'b1, 5'h00, 8'ha0, rd);
        bus(1'b1, 5'h00, 8'h20, rd);
        bus(1'b0, 5'h00, 8'h0, rd);
        chk("busy set", 32'h60, rd);
        bus(1'b1, 5'h00, 8'ha0, rd);
        bus(1'b1, 5'h00, 8'h20, rd);
        for (int i = 0; i < 500 && irqs < 1; i++) @(posedge sys_clk);
        chk("requests", 32'd1, irqs);
        chk("starts", 32'd1, starts);
        bus(1'b0, 5'h00, 8'h0, rd);
        chk("busy clear", 32'h20, rd);
        bus(1'b0, 5'h08, 8'h0, rd);
        chk("high left", 32'ha5, rd);
        bus(1'b0, 5'h0c, 8'h0, rd);
        chk("low left", 32'hc0, rd);
        bus(1'b1, 5'h00, 8'h30, rd);
        bus(1'b0, 5'h08, 8'h0, rd);
        chk("high right", 32'h0a, rd);
        t0 = ticks;
        repeat (64) @(posedge sys_clk);
        chk("divided clock", 32'd8, ticks - t0);
        res_val <= 12'h3c1;
        bus(1'b1, 5'h00, 8'hb0, rd);
        bus(1'b1, 5'h00, 8'h30, rd);
        bus(1'b1, 5'h00, 8'h10, rd);
        bus(1'b1, 5'h00, 8'h90, rd);
        bus(1'b1, 5'h00, 8'h10, rd);
        repeat (100) @(posedge sys_clk);
        chk("starts off", 32'd2, starts);
        chk("requests off", 32'd1, irqs);
        bus(1'b0, 5'h0c, 8'h0, rd);
        chk("low kept", 32'h5c, rd);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(1'b0, 5'h10, 8'h0, rd);
        chk("pins after reset", 32'h0, rd);
        chk("pull-ups after reset", 32'hff, {24'h0, pin_pullup_en});
        chk("select after reset", 32'h002, {21'h0, core_ctl[10:0]});
        results();
    end
endmodule // adc_control_registers_test

// *** verif/adcc_core_model.sv ***
// behavioural analog converter core
`timescale 1ns/100ps
module adcc_core_model
    import adcc_pkg::*;
(
    input wire logic           SYS_CLK,    // clock
    input wire adcc_core_ctl_t CORE_CTL,   // controls
    input wire logic [11:0]    RES_VAL,    // value to report
    output logic               CONV_DONE,  // finish pulse
    output logic [11:0]        CONV_RESULT // result with finish
);
    int left = -1;
    initial CONV_DONE = 1'b0;
    initial CONV_RESULT = 12'h000;
    // result only valid with the pulse, garbage otherwise
    always @(posedge SYS_CLK) begin
        CONV_DONE <= 1'b0;
        CONV_RESULT <= ~CONV_RESULT;
        if (!CORE_CTL.power_en) left <= -1;
        else if (CORE_CTL.conv_start) left <= 4;
        else if (left > 0 && CORE_CTL.clk_en) left <= left - 1;
        else if (left == 0) begin
            CONV_DONE <= 1'b1;
            CONV_RESULT <= RES_VAL;
            left <= -1;
        end
    end
endmodule // adcc_core_model

// *** verif/adcc_ctrl_checker.sv ***
// port assertions for the converter control block
`timescale 1ns/100ps
module adcc_ctrl_checker
    import adcc_pkg::*;
(
    input wire logic           SYS_CLK,       // clock
    input wire logic           ARST_N,        // reset
    input wire logic           HSEL,          // select
    input wire logic [1:0]     HTRANS,        // kind
    input wire logic           HREADYOUT,     // ready
    input wire logic           CONV_DONE,     // done
    input wire adcc_core_ctl_t CORE_CTL,      // core
    input wire logic           IRQ_REQ,       // request
    input wire logic [7:0]     PORT_PULLUP,   // pulls
    input wire logic [7:0]     PIN_PULLUP_EN, // pulls out
    input wire logic [7:0]     PIN_ANALOG_EN  // analog
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    sequence wait_then_ready;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    ready_wait_a: assert property (HSEL && HTRANS[1] && HREADYOUT |=> wait_then_ready)
        else $error("bus wait wrong");
    start_pulse_a: assert property (CORE_CTL.conv_start |=> !CORE_CTL.conv_start)
        else $error("start too long");
    start_power_a: assert property (CORE_CTL.conv_start |-> CORE_CTL.power_en)
        else $error("start unpowered");
    done_irq_a: assert property (IRQ_REQ |-> $past(CONV_DONE) ##1 !IRQ_REQ)
        else $error("request wrong");
    clk_idle_a: assert property (!CORE_CTL.power_en && !$past(CORE_CTL.power_en) |-> !CORE_CTL.clk_en)
        else $error("clock while off");
    pullup_gate_a: assert property (PIN_PULLUP_EN == (PORT_PULLUP & ~PIN_ANALOG_EN))
        else $error("pull-up on analog pin");
    chan_onehot_a: assert property ($onehot0(CORE_CTL.channel_en))
        else $error("two channels");
    chan_source_a: assert property (CORE_CTL.input_kind != ADCC_IN_EXTERNAL |-> CORE_CTL.channel_en == 8'h00)
        else $error("channel with inner source");
endmodule // adcc_ctrl_checker

bind adcc_ctrl adcc_ctrl_checker u_adcc_ctrl_checker (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL),
    .HTRANS(HTRANS), .HREADYOUT(HREADYOUT), .CONV_DONE(CONV_DONE), .CORE_CTL(CORE_CTL), .IRQ_REQ(IRQ_REQ),
    .PORT_PULLUP(PORT_PULLUP), .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_ANALOG_EN(PIN_ANALOG_EN));
